//--- bench/serial_peer.sv
// Purpose: remote serial device on the receive and transmit pins
// Assumes: bit time handed in as a count of MCLK cycles
// Notes:   released line goes high, as with a pull-up
`timescale 1ns/10ps
module serial_peer (
	input  wire logic clk,
	input  wire logic txd,
	input  wire logic rxd,
	output      logic line
);
	int cyc;
	initial line = 1'b1;
	initial cyc = 0;
	// counted on the falling clock edge, so it is settled whenever
	// the shift clock moves just after a rising one
	always @(negedge clk) cyc <= cyc + 1;
	// ********************************
	// frame drive and capture
	// ********************************
	// start low, bits lsb first, then the chosen stop level
	task automatic send(input logic [8:0] d, input int n, input logic stp, input int bc);
		line <= 1'b0;
		repeat (bc) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			line <= d[i];
			repeat (bc) @(posedge clk);
		end
		line <= stp;
		repeat (bc) @(posedge clk);
		line <= 1'b1;
	endtask
	// long low run, used to make a break
	task automatic low(input int c);
		line <= 1'b0;
		repeat (c) @(posedge clk);
		line <= 1'b1;
	endtask
	// w counts idle cycles, so back to back frames can be judged
	task automatic recv(input int n, input int bc, output logic [8:0] d, output logic stp,
			output int w);
		w = 0;
		d = '0;
		@(posedge clk);
		while (txd !== 1'b0) begin
			w++;
			@(posedge clk);
		end
		repeat (bc / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (bc) @(posedge clk);
			d[i] = txd;
		end
		repeat (bc) @(posedge clk);
		stp = txd;
	endtask
	// mode 0 send: data pin read at each rising shift clock, period
	// taken between the last two rising edges
	task automatic shift_in(output logic [7:0] d, output int per);
		int t0;
		t0 = 0;
		per = 0;
		d = '0;
		for (int i = 0; i < 8; i++) begin
			@(posedge txd);
			d[i] = rxd;
			per = cyc - t0;
			t0 = cyc;
		end
	endtask
	// mode 0 receive: next bit after each falling shift clock, held
	// well past the sample at the end of the high half
	task automatic shift_out(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge txd);
			line <= d[i];
		end
		repeat (24) @(posedge clk);
		line <= 1'b1;
	endtask
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench for the enhanced serial port
// Assumes: bit times of 16 or 32 cycles chosen through the registers
// Notes:   shift mode judged by the peer's shift clock tasks
`timescale 1ns/10ps
module tb;
	import enhanced_uart_pkg::*;
	logic       mclk;
	logic       rst_b;
	axi_req_t   req;
	axi_rsp_t   rsp;
	logic       rxd_o;
	logic       rxd_oe_b;
	logic       rxd_wire;
	logic       txd;
	logic       t1_ovf;
	logic       brk_rst;
	logic       boot_sel;
	logic       peer_line;
	logic [7:0] rdat;
	logic [1:0] resp;
	int         err_total;
	int         compares;
	// pin level: device drives only while its enable is low
	assign rxd_wire = rxd_oe_b ? peer_line : rxd_o;
	enhanced_uart_core DUT (
		.MCLK       (mclk),
		.RST_B      (rst_b),
		.AXI_REQ    (req),
		.AXI_RSP    (rsp),
		.RXD_I      (rxd_wire),
		.RXD_O      (rxd_o),
		.RXD_OE_B   (rxd_oe_b),
		.TXD        (txd),
		.T1_OVF     (t1_ovf),
		.BREAK_RESET(brk_rst),
		.BOOT_SELECT(boot_sel)
	);
	serial_peer peer (
		.clk (mclk),
		.txd (txd),
		.rxd (rxd_wire),
		.line(peer_line)
	);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ********************************
	// shared tasks
	// ********************************
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.awaddr <= a;
		req.wdata <= {24'h000000, d};
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		resp = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) break;
		end
		rdat = rsp.rdata[7:0];
		resp = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge mclk);
	endtask
	// one frame out of the device, judged by the peer
	task automatic tx_one(input logic [8:0] d, input int n, input int bc);
		logic [8:0] got;
		logic       stp;
		int         w;
		fork
			peer.recv(n, bc, got, stp, w);
			wr(OFF_DATA, d[7:0]);
		join
		chk("tx_data", d, got);
		chk("tx_stop", 9'h001, 9'(stp));
	endtask
	// ********************************
	// scenarios
	// ********************************
	task automatic t_regs;
		rd(OFF_CTRL);
		chk("ctrl_reset", 9'(CTRL_RST), 9'(rdat));
		rd(OFF_DIVH);
		chk("divh_reset", 9'(DIV_RST), 9'(rdat));
		rd(8'h1c);
		chk("unmapped_resp", 9'(AXI_SLVERR), 9'(resp));
		wr(8'h1c, 8'h00);
		chk("unmapped_wr", 9'(AXI_SLVERR), 9'(resp));
		wr(OFF_PWR, 8'hff);
		chk("pwr_wr_resp", 9'(AXI_OKAY), 9'(resp));
		rd(OFF_PWR);
		chk("pwr_bits", 9'(PWR_RMASK), 9'(rdat));
	endtask
	// fixed and timer rates, ninth bit taken from control
	task automatic t_tx_rates;
		wr(OFF_PWR, 8'h80);
		wr(OFF_CTRL, 8'h88);
		tx_one(9'h1a5, 9, 16);
		wr(OFF_PWR, 8'h00);
		// let the first frame end, then clear its done flag
		repeat (24) @(posedge mclk);
		wr(OFF_CTRL, 8'h88);
		tx_one(9'h1a5, 9, 32);
		rd(OFF_CTRL);
		chk("tx_busy", 9'h000, 9'(rdat & 8'h02));
		repeat (24) @(posedge mclk);
		rd(OFF_CTRL);
		chk("tx_done", 9'h002, 9'(rdat & 8'h02));
		t1_ovf <= 1'b1;
		// ninth bit changed only once the done flag is up
		wr(OFF_CTRL, 8'hc0);
		tx_one(9'h05a, 9, 32);
		wr(OFF_PWR, 8'h80);
		tx_one(9'h0c3, 9, 16);
		t1_ovf <= 1'b0;
	endtask
	// ninth bit kept, stop level dropped
	task automatic t_rx9;
		wr(OFF_CTRL, 8'h90);
		peer.send(9'h03c, 9, 1'b1, 16);
		rd(OFF_DATA);
		chk("rx9_data", 9'h03c, 9'(rdat));
		rd(OFF_CTRL);
		chk("rx9_ninth0", 9'h001, 9'(rdat & 8'h05));
		peer.send(9'h1c3, 9, 1'b1, 16);
		rd(OFF_CTRL);
		chk("rx9_ninth1", 9'h005, 9'(rdat & 8'h05));
	endtask
	// generator rate, stop stored, framing error views
	task automatic t_rx8;
		wr(OFF_BCFG, 8'h01);
		wr(OFF_DIVL, 8'h01);
		wr(OFF_PWR, 8'h00);
		wr(OFF_CTRL, 8'h50);
		tx_one(9'h05a, 8, 32);
		peer.send(9'h0c3, 8, 1'b1, 32);
		rd(OFF_DATA);
		chk("rx8_data", 9'h0c3, 9'(rdat));
		rd(OFF_CTRL);
		chk("rx8_stop", 9'h004, 9'(rdat & 8'h04));
		peer.send(9'h0c3, 8, 1'b0, 32);
		rd(OFF_STAT);
		chk("fe_status", 9'h008, 9'(rdat & 8'h08));
		wr(OFF_PWR, 8'h40);
		rd(OFF_CTRL);
		chk("fe_view", 9'h080, 9'(rdat & 8'h80));
		wr(OFF_PWR, 8'h00);
		rd(OFF_CTRL);
		chk("mode_view", 9'h000, 9'(rdat & 8'h80));
	endtask
	// short low run is no break, a long one resets to boot
	task automatic t_break;
		logic saw;
		saw = 1'b0;
		wr(OFF_BCFG, 8'h03);
		wr(OFF_DIVL, 8'h00);
		wr(OFF_STAT, 8'h00);
		peer.low(150);
		repeat (40) @(posedge mclk);
		rd(OFF_STAT);
		chk("no_break", 9'h000, 9'(rdat & 8'h04));
		fork
			peer.low(200);
			repeat (260) begin
				@(posedge mclk);
				if (brk_rst === 1'b1) saw = 1'b1;
			end
		join
		chk("break_reset", 9'h001, 9'(saw));
		rd(OFF_STAT);
		chk("break_flag", 9'h004, 9'(rdat & 8'h04));
		chk("boot_set", 9'h001, 9'(boot_sel));
		wr(OFF_BCFG, 8'h01);
		chk("boot_clear", 9'h000, 9'(boot_sel));
	endtask
	// second byte queued mid frame follows the stop at once
	task automatic t_dbuf;
		logic [8:0] g1;
		logic [8:0] g2;
		logic       s1;
		logic       s2;
		int         w1;
		int         w2;
		wr(OFF_STAT, 8'h80);
		wr(OFF_CTRL, 8'h50);
		fork
			begin
				peer.recv(8, 16, g1, s1, w1);
				peer.recv(8, 16, g2, s2, w2);
			end
			begin
				wr(OFF_DATA, 8'h11);
				rd(OFF_CTRL);
				chk("db_done_early", 9'h002, 9'(rdat & 8'h02));
				wr(OFF_DATA, 8'h22);
			end
		join
		chk("db_first", 9'h011, g1);
		chk("db_second", 9'h022, g2);
		chk("db_gap", 9'h001, 9'(w2 <= 9));
		wr(OFF_STAT, 8'h00);
	endtask
	// mode 0: data on the receive pin, shift clock on the transmit pin
	task automatic t_shift;
		logic [7:0] g;
		int         per;
		repeat (24) @(posedge mclk);
		wr(OFF_CTRL, 8'h00);
		fork
			peer.shift_in(g, per);
			wr(OFF_DATA, 8'ha5);
		join
		chk("m0_tx_data", 9'h0a5, 9'(g));
		chk("m0_tx_rate", 9'h010, 9'(per));
		fork
			peer.shift_out(8'h3c);
			wr(OFF_CTRL, 8'h10);
		join
		rd(OFF_DATA);
		chk("m0_rx_data", 9'h03c, 9'(rdat));
	endtask
	// ********************************
	// main sequence and watchdog
	// ********************************
	initial begin
		req = '0;
		t1_ovf = 1'b0;
		rst_b = 1'b0;
		err_total = 0;
		compares = 0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_tx_rates();
		t_rx9();
		t_rx8();
		t_break();
		t_dbuf();
		t_shift();
		report_and_stop();
	end
	// all scenarios need well under 20000 cycles
	initial begin
		repeat (30000) @(posedge mclk);
		err_total++;
		report_and_stop();
	end
endmodule

//--- hdl/enhanced_uart_core.sv
// Purpose: enhanced serial port with shift, 8-bit and 9-bit modes
// Assumes: MCLK is both the CPU clock and the oscillator clock
// Notes:   registers over AXI4-Lite; flags cleared by writing 0
// Notes on behaviour
// R1: mode 0 shifts 8 bits, clock at cpu/16
// R2: 8-bit mode frame: start, 8 data, stop
// R3: 8-bit mode stores stop bit as ninth
// R4: 8-bit mode rate from timer1 or generator
// R5: fixed 9-bit frame: start, 8 data, ninth, stop
// R6: 9-bit modes keep ninth bit, drop stop
// R7: fixed 9-bit rate cpu/16 or cpu/32
// R8: variable 9-bit equals fixed, variable rate
// R9: generator divisor is two 8-bit registers
// R10: generator runs on the oscillator clock
// R11: timer1 rate halved when baud_double clear
// R12: framing error in status, optionally control bit 7
// R13: software sets mode bits with select low
// R14: eleven low bit times flag a break
// R15: break may force reset into programming mode
// R16: break reset fetches from boot address
// R17: double buffer sends back to back frames
// R18: status bit 7 enables double buffering
// R19: software keeps double buffering off in mode 0
// R20: double buffer raises done when buffer frees
// R21: single buffer ninth bit held until sent
// R22: double buffer captures ninth bit with data
// R23: no timer2 rate source exists
// R24: start on falling edge, sample mid bit
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module enhanced_uart_core
	import enhanced_uart_pkg::*;
(
	input  wire logic                        MCLK,
	input  wire logic                        RST_B,
	input  wire enhanced_uart_pkg::axi_req_t AXI_REQ,
	output      enhanced_uart_pkg::axi_rsp_t AXI_RSP,
	input  wire logic                        RXD_I,
	output      logic                        RXD_O,
	output      logic                        RXD_OE_B,
	output      logic                        TXD,
	input  wire logic                        T1_OVF,
	output      logic                        BREAK_RESET,
	output      logic                        BOOT_SELECT
);
	import enhanced_uart_pkg::*;

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		logic        rx_meta;
		logic        rx_sync;
		logic        rx_prev;
		logic [7:0]  ctrl;
		logic        dbe;
		logic        fe;
		logic        brk;
		logic [7:0]  pwr;
		logic [7:0]  divl;
		logic [7:0]  divh;
		logic        src_brg;
		logic        bre;
		logic        boot_sel;
		logic        brk_rst;
		logic        fix_half;
		logic        t1_half;
		logic [15:0] brg_cnt;
		logic [7:0]  brk_cnt;
		tx_state_t   tx_st;
		logic [10:0] tx_shift;
		logic [3:0]  tx_cnt;
		logic [3:0]  tx_bit;
		logic        tx_live;
		logic        m0_rx;
		logic        hold_v;
		logic [7:0]  hold_d;
		logic        hold_b8;
		rx_state_t   rx_st;
		logic [3:0]  rx_cnt;
		logic [3:0]  rx_bit;
		logic [8:0]  rx_buf;
		logic [7:0]  rx_data;
		logic        txd;
		logic        rxd_o;
		logic        rxd_oe_b;
		logic        aw_v;
		logic [7:0]  aw_a;
		logic        w_v;
		logic [7:0]  w_d;
		logic        w_s;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
	} state_t;

	state_t s_reg;
	state_t s_next;
	mode_t  mode;
	logic   smod;
	logic   fes;
	logic   async;
	logic   os_tick;
	logic   brg_tick;
	logic   t1_tick;
	logic   brk_hit;
	logic   take;
	logic   wr_data;
	logic   rx_done;
	logic   fe_view;
	logic   rd_ok;
	logic [7:0] rd_val;
	logic [3:0] tx_last;
	logic   tx_bit_out;

	// frame image, lsb leaves first
	function automatic logic [10:0] frame_of(mode_t m, logic [7:0] d, logic b8);
		logic [10:0] f;
		f = {3'h7, d};
		if (m == MODE_8BIT) begin
			f = {2'h3, d, 1'b0}; // [R2]
		end else if (m != MODE_SHIFT) begin
			f = {1'b1, b8, d, 1'b0}; // [R5] [R8]
		end
		return f;
	endfunction

	assign mode  = mode_t'(s_reg.ctrl[CTL_MSH:CTL_MSL]);
	assign smod  = s_reg.pwr[PW_BD];
	assign fes   = s_reg.pwr[PW_FES];
	assign async = (mode != MODE_SHIFT);
	assign tx_last = (mode == MODE_SHIFT) ? 4'h7 : (mode == MODE_8BIT) ? 4'h9 : 4'ha;
	// control bit 7 shows the error flag when selected
	assign fe_view = fes ? s_reg.fe : s_reg.ctrl[CTL_MSH]; // [R12]

	// ********************************
	// register read decode
	// ********************************
	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 8'h00;
		case (AXI_REQ.araddr)
			OFF_CTRL: rd_val = {fe_view, s_reg.ctrl[6:0]} & CTL_RMASK; // [R12]
			OFF_DATA: rd_val = s_reg.rx_data;
			OFF_STAT: begin
				rd_val[ST_DBE] = s_reg.dbe;
				rd_val[ST_FE]  = s_reg.fe; // [R12]
				rd_val[ST_BRK] = s_reg.brk; // [R14]
			end
			OFF_PWR:  rd_val = s_reg.pwr & PWR_RMASK;
			OFF_DIVL: rd_val = s_reg.divl;
			OFF_DIVH: rd_val = s_reg.divh;
			OFF_BCFG: begin
				rd_val[CF_SRC]  = s_reg.src_brg;
				rd_val[CF_BRE]  = s_reg.bre;
				rd_val[CF_BOOT] = s_reg.boot_sel;
			end
			default:  rd_ok = 1'b0;
		endcase
	end

	// ********************************
	// next state
	// ********************************
	always_comb begin
		s_next  = s_reg;
		s_next.brk_rst = 1'b0;
		wr_data = 1'b0;
		take    = 1'b0;
		rx_done = 1'b0;
		tx_bit_out = 1'b1;
		// two-stage pin synchroniser, edge seen after it
		s_next.rx_meta = RXD_I;
		s_next.rx_sync = s_reg.rx_meta;
		s_next.rx_prev = s_reg.rx_sync;

		// rate: generator counts oscillator cycles, MCLK here [R9] [R10]
		brg_tick = (s_reg.brg_cnt >= {s_reg.divh, s_reg.divl});
		s_next.brg_cnt = brg_tick ? 16'h0000 : s_reg.brg_cnt + 16'h0001;
		s_next.fix_half = ~s_reg.fix_half;
		if (T1_OVF && !smod) begin
			s_next.t1_half = ~s_reg.t1_half; // [R11]
		end
		t1_tick = T1_OVF && (smod || s_reg.t1_half); // [R11]
		// only three sources; timer2 has no path here [R23]
		case (mode)
			MODE_SHIFT: os_tick = 1'b1; // sixteen ticks a bit: cpu/16 [R1]
			MODE_9FIX:  os_tick = smod || s_reg.fix_half; // [R7]
			default:    os_tick = s_reg.src_brg ? brg_tick : t1_tick; // [R4] [R8]
		endcase

		// bus: address and data taken in either order
		if (AXI_REQ.awvalid && !s_reg.aw_v) begin
			s_next.aw_v = 1'b1;
			s_next.aw_a = AXI_REQ.awaddr;
		end
		if (AXI_REQ.wvalid && !s_reg.w_v) begin
			s_next.w_v = 1'b1;
			s_next.w_d = AXI_REQ.wdata[7:0];
			s_next.w_s = AXI_REQ.wstrb[0];
		end
		if (s_reg.bvalid && AXI_REQ.bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_v && s_reg.w_v && !s_reg.bvalid) begin
			s_next.aw_v   = 1'b0;
			s_next.w_v    = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp  = AXI_OKAY;
			case (s_reg.aw_a)
				OFF_CTRL: if (s_reg.w_s) begin
					s_next.ctrl = s_reg.w_d;
					if (fes) begin
						// bit 7 aliases the error flag; mode bit kept [R12]
						s_next.ctrl[CTL_MSH] = s_reg.ctrl[CTL_MSH];
						s_next.fe = s_reg.fe & s_reg.w_d[CTL_MSH];
					end
				end
				OFF_DATA: if (s_reg.w_s) begin
					wr_data = 1'b1;
					s_next.hold_v  = 1'b1;
					s_next.hold_d  = s_reg.w_d;
					s_next.hold_b8 = s_reg.ctrl[CTL_TB8]; // ninth bit latched now [R22]
				end
				OFF_STAT: if (s_reg.w_s) begin
					s_next.dbe = s_reg.w_d[ST_DBE]; // [R18]
					s_next.fe  = s_reg.fe & s_reg.w_d[ST_FE];
					s_next.brk = s_reg.brk & s_reg.w_d[ST_BRK];
				end
				OFF_PWR:  if (s_reg.w_s) s_next.pwr = s_reg.w_d;
				OFF_DIVL: if (s_reg.w_s) s_next.divl = s_reg.w_d; // [R9]
				OFF_DIVH: if (s_reg.w_s) s_next.divh = s_reg.w_d; // [R9]
				OFF_BCFG: if (s_reg.w_s) begin
					s_next.src_brg  = s_reg.w_d[CF_SRC]; // [R4]
					s_next.bre      = s_reg.w_d[CF_BRE];
					s_next.boot_sel = s_reg.boot_sel & s_reg.w_d[CF_BOOT];
				end
				default:  s_next.bresp = AXI_SLVERR;
			endcase
		end
		if (AXI_REQ.arvalid && !s_reg.rvalid) begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = rd_val;
			s_next.rresp  = rd_ok ? AXI_OKAY : AXI_SLVERR;
		end else if (s_reg.rvalid && AXI_REQ.rready) begin
			s_next.rvalid = 1'b0;
		end

		// transmitter; flag sets come after bus writes so they win
		case (s_reg.tx_st)
			TX_IDLE: begin
				if (s_reg.hold_v) begin
					take = 1'b1;
				end else if (!async && s_reg.ctrl[CTL_REN] && !s_reg.ctrl[CTL_RI]) begin
					// mode 0 receive: clock out, sample the data pin [R1]
					s_next.tx_st    = TX_SHIFT;
					s_next.tx_shift = 11'h7ff;
					s_next.m0_rx    = 1'b1;
					s_next.tx_cnt   = 4'h0;
					s_next.tx_bit   = 4'h0;
				end
			end
			TX_SHIFT: if (os_tick) begin
				s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
				if (s_reg.tx_cnt == OS_LAST) begin
					s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
					s_next.tx_bit   = s_reg.tx_bit + 4'h1;
					if (s_reg.m0_rx) begin
						s_next.rx_buf[s_reg.tx_bit[2:0]] = s_reg.rx_sync; // [R1]
					end
					if (s_reg.tx_bit == tx_last) begin
						s_next.tx_st = TX_IDLE;
						if (s_reg.m0_rx) begin
							s_next.rx_data = {s_reg.rx_sync, s_reg.rx_buf[6:0]};
							s_next.ctrl[CTL_RI] = 1'b1;
						end else if (!s_reg.dbe || !async) begin
							s_next.ctrl[CTL_TI] = 1'b1; // end of char [R18] [R19]
						end
						// next frame starts right after this stop bit [R17]
						if (s_reg.hold_v && s_reg.dbe && async) begin
							take = 1'b1;
						end
					end
				end
			end
			default: s_next.tx_st = TX_IDLE;
		endcase
		if (take) begin
			s_next.tx_st    = TX_SHIFT;
			s_next.tx_shift = frame_of(mode, s_reg.hold_d, s_reg.hold_b8);
			s_next.tx_live  = !s_reg.dbe; // [R21]
			s_next.m0_rx    = 1'b0;
			s_next.tx_cnt   = 4'h0;
			s_next.tx_bit   = 4'h0;
			if (!wr_data) begin
				s_next.hold_v = 1'b0;
			end
			if (s_reg.dbe && async) begin
				s_next.ctrl[CTL_TI] = 1'b1; // buffer free again [R20]
			end
		end

		// asynchronous receiver
		case (s_reg.rx_st)
			RX_IDLE: if (async && s_reg.ctrl[CTL_REN] && s_reg.rx_prev && !s_reg.rx_sync) begin
				s_next.rx_st  = RX_START; // falling edge [R24]
				s_next.rx_cnt = 4'h0;
			end
			RX_START: if (os_tick) begin
				s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
				if (s_reg.rx_cnt == OS_MID) begin
					// a glitch that is high mid start is dropped
					s_next.rx_st  = s_reg.rx_sync ? RX_IDLE : RX_DATA; // [R24]
					s_next.rx_cnt = 4'h0;
					s_next.rx_bit = 4'h0;
				end
			end
			RX_DATA: if (os_tick) begin
				s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
				if (s_reg.rx_cnt == OS_LAST) begin
					s_next.rx_bit = s_reg.rx_bit + 4'h1;
					if (s_reg.rx_bit == tx_last - 4'h1) begin
						rx_done = 1'b1;
						s_next.rx_st   = RX_IDLE;
						s_next.rx_data = s_reg.rx_buf[7:0];
						s_next.ctrl[CTL_RI] = 1'b1;
						if (mode == MODE_8BIT) begin
							s_next.ctrl[CTL_RB8] = s_reg.rx_sync; // stop bit kept [R3]
						end else begin
							s_next.ctrl[CTL_RB8] = s_reg.rx_buf[8]; // stop dropped [R6]
						end
						if (!s_reg.rx_sync) begin
							s_next.fe = 1'b1; // [R12]
						end
					end else begin
						s_next.rx_buf[s_reg.rx_bit] = s_reg.rx_sync; // [R2] [R5]
					end
				end
			end
			default: s_next.rx_st = RX_IDLE;
		endcase

		// break: line low for eleven whole bit times
		brk_hit = os_tick && async && !s_reg.rx_sync && (s_reg.brk_cnt == BRK_TICKS - 8'h01);
		if (os_tick && async) begin
			if (s_reg.rx_sync) begin
				s_next.brk_cnt = 8'h00;
			end else if (s_reg.brk_cnt != BRK_TICKS) begin
				s_next.brk_cnt = s_reg.brk_cnt + 8'h01;
			end
		end
		if (brk_hit) begin
			s_next.brk = 1'b1; // [R14]
			if (s_reg.bre) begin
				s_next.brk_rst  = 1'b1; // [R15]
				s_next.boot_sel = 1'b1; // [R16]
			end
		end

		// pin images from flip-flops; mode 0 clock low in first half
		if (s_next.tx_st == TX_SHIFT && !async) begin
			s_next.txd = (s_next.tx_cnt > OS_MID); // [R1]
		end else if (s_next.tx_st == TX_SHIFT) begin
			tx_bit_out = s_next.tx_shift[0];
			if (s_next.tx_bit == 4'h9 && mode[1] && s_next.tx_live) begin
				tx_bit_out = s_next.ctrl[CTL_TB8]; // live ninth bit [R21]
			end
			s_next.txd = tx_bit_out;
		end else begin
			s_next.txd = 1'b1;
		end
		s_next.rxd_o    = s_next.tx_shift[0];
		s_next.rxd_oe_b = !(!async && s_next.tx_st == TX_SHIFT && !s_next.m0_rx); // [R1]
	end

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			s_reg          <= '0;
			s_reg.ctrl     <= CTRL_RST;
			s_reg.pwr      <= PWR_RST;
			s_reg.divl     <= DIV_RST;
			s_reg.divh     <= DIV_RST;
			s_reg.rx_meta  <= 1'b1;
			s_reg.rx_sync  <= 1'b1;
			s_reg.rx_prev  <= 1'b1;
			s_reg.txd      <= 1'b1;
			s_reg.rxd_o    <= 1'b1;
			s_reg.rxd_oe_b <= 1'b1;
			s_reg.tx_st    <= TX_IDLE;
			s_reg.rx_st    <= RX_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign TXD         = s_reg.txd;
	assign RXD_O       = s_reg.rxd_o;
	assign RXD_OE_B    = s_reg.rxd_oe_b;
	assign BREAK_RESET = s_reg.brk_rst;
	assign BOOT_SELECT = s_reg.boot_sel;
	assign AXI_RSP = '{awready: !s_reg.aw_v, wready: !s_reg.w_v, bvalid: s_reg.bvalid,
		bresp: s_reg.bresp, arready: !s_reg.rvalid, rvalid: s_reg.rvalid,
		rdata: {24'h000000, s_reg.rdata}, rresp: s_reg.rresp};

	// ********************************
	// checks
	// ********************************
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	sequence armed_break;
		brk_hit && s_reg.bre;
	endsequence
	sequence reset_pulse;
		BREAK_RESET ##1 !BREAK_RESET;
	endsequence
	sequence ctrl_read;
		AXI_REQ.arvalid && !s_reg.rvalid && AXI_REQ.araddr == OFF_CTRL;
	endsequence

	AST_BRK_FLAG: assert property (brk_hit |=> s_reg.brk) // [R14]
		else $error("break not flagged");
	AST_BRK_RST: assert property (armed_break |=> reset_pulse) // [R15]
		else $error("break reset pulse wrong");
	AST_BOOT: assert property (armed_break |=> BOOT_SELECT) // [R16]
		else $error("boot select not set");
	AST_FE_VIEW: assert property (ctrl_read |=> AXI_RSP.rdata[7] == $past(fe_view)) // [R12]
		else $error("control bit 7 view wrong");
	// judged only while the mode and baud_double bit stay put across both cycles
	AST_M2_RATE: assert property ((os_tick && mode == MODE_9FIX && !smod) // [R7]
		##1 (mode == MODE_9FIX && !smod) |-> !os_tick)
		else $error("fixed rate too fast");
	AST_T1_HALF: assert property ((async && mode != MODE_9FIX && !s_reg.src_brg && !smod
		&& T1_OVF && !s_reg.t1_half) |-> !os_tick) // [R11]
		else $error("timer1 not halved");
	AST_START_LOW: assert property ((take && async) |=> !TXD) // [R2]
		else $error("start bit not low");
	AST_DB_TI: assert property ((take && s_reg.dbe && async) |=> s_reg.ctrl[CTL_TI]) // [R20]
		else $error("done flag not raised on buffer free");
	AST_RB8_M1: assert property ((rx_done && mode == MODE_8BIT)
		|=> s_reg.ctrl[CTL_RB8] == $past(s_reg.rx_sync)) // [R3]
		else $error("stop bit not stored");
endmodule

//--- hdl/enhanced_uart_pkg.sv
// Purpose: shared constants and types for the enhanced serial port
// Assumes: AXI4-Lite register access, one 40 MHz clock (MCLK)
// Notes:   offsets are byte addresses, one aligned word per register
package enhanced_uart_pkg;
	// ********************************
	// register map
	// ********************************
	localparam logic [7:0] OFF_CTRL = 8'h00; // serial_control_reg
	localparam logic [7:0] OFF_DATA = 8'h04; // serial_data_buffer
	localparam logic [7:0] OFF_STAT = 8'h08; // serial_status_reg
	localparam logic [7:0] OFF_PWR  = 8'h0c; // power_control_reg
	localparam logic [7:0] OFF_DIVL = 8'h10; // divisor_low_byte
	localparam logic [7:0] OFF_DIVH = 8'h14; // divisor_high_byte
	localparam logic [7:0] OFF_BCFG = 8'h18; // rate source / break options
	// field positions
	localparam int CTL_MSH = 7;
	localparam int CTL_MSL = 6;
	localparam int CTL_REN = 4;
	localparam int CTL_TB8 = 3;
	localparam int CTL_RB8 = 2;
	localparam int CTL_TI  = 1;
	localparam int CTL_RI  = 0;
	localparam int ST_DBE  = 7;
	localparam int ST_FE   = 3;
	localparam int ST_BRK  = 2;
	localparam int PW_BD   = 7;
	localparam int PW_FES  = 6;
	localparam int CF_SRC  = 0;
	localparam int CF_BRE  = 1;
	localparam int CF_BOOT = 2;
	// reset values and read masks
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] PWR_RST   = 8'h00;
	localparam logic [7:0] DIV_RST   = 8'h00;
	localparam logic [7:0] CTL_RMASK = 8'hdf;
	localparam logic [7:0] PWR_RMASK = 8'hc0;
	// timing
	localparam int          OS_PER_BIT = 16;
	localparam int          BRK_BITS   = 11;
	localparam logic [7:0]  BRK_TICKS  = 8'(BRK_BITS * OS_PER_BIT);
	localparam logic [3:0]  OS_LAST    = 4'(OS_PER_BIT - 1);
	localparam logic [3:0]  OS_MID     = 4'(OS_PER_BIT / 2 - 1);
	localparam logic [1:0]  AXI_OKAY   = 2'h0;
	localparam logic [1:0]  AXI_SLVERR = 2'h2;
	// ********************************
	// types
	// ********************************
	typedef enum logic [1:0] {MODE_SHIFT, MODE_8BIT, MODE_9FIX, MODE_9VAR} mode_t;
	typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA} rx_state_t;
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axi_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;
endpackage
